// ### tpc_channel.sv
// One timer channel: compare/PWM pin action and input-capture edges.
// Assumes pin_sync is already synchronised and cmp_hit/ovf are one-cycle.
`timescale 1ns/1ns
module tpc_channel
  import tpc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  tpc_chsc_t      ctrl,
  input  wire logic      enable,
  input  wire logic      cmp_hit,
  input  wire logic      ovf,
  input  wire logic      pin_sync,
  output logic           pin_drive,
  output logic           pin_oe,
  output logic           cap_evt,
  output logic           cmp_evt
);

  logic pin_r, pin_nxt, oe_nxt, max_r, max_nxt, prev_r, out_mode, cap_mode;

  // ==========================================================================
  // Buffered and unbuffered bits are ORed into one output mode; neither is tested first
  always_comb begin
    out_mode = enable & (ctrl.msb | ctrl.msa) & (ctrl.els != TPC_ELS_OFF);
    cap_mode = enable & ~ctrl.msb & ~ctrl.msa & (ctrl.els != TPC_ELS_OFF);
    oe_nxt   = out_mode;
    max_nxt  = ovf ? ctrl.maxd : max_r;
    pin_nxt  = pin_r;
    cmp_evt  = out_mode & cmp_hit;
    cap_evt  = cap_mode & ((ctrl.els[0] & pin_sync & ~prev_r) | (ctrl.els[1] & ~pin_sync & prev_r));
    if (!out_mode) begin
      pin_nxt = ~ctrl.msa;                    // Preset level for a later start
    end else if (ovf && ctrl.tov) begin
      // Overflow beats a same-cycle compare; max duty parks at pulse level
      if (ctrl.maxd && ctrl.els != TPC_ELS_TGL) begin
        pin_nxt = ctrl.els != TPC_ELS_SET;
      end else begin
        pin_nxt = ~pin_r;
      end
    end else if (cmp_hit && !(max_r && ctrl.tov)) begin
      // Compare action: toggle inverts, clear drives 0, set drives 1; skipped at max duty with overflow toggle
      unique case (ctrl.els)
        TPC_ELS_TGL: pin_nxt = ~pin_r;
        TPC_ELS_CLR: pin_nxt = 1'b0;
        TPC_ELS_SET: pin_nxt = 1'b1;
        TPC_ELS_OFF: pin_nxt = pin_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r  <= 1'b1;
      pin_oe <= 1'b0;
      max_r  <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      pin_r  <= pin_nxt;
      pin_oe <= oe_nxt;
      max_r  <= max_nxt;
      prev_r <= pin_sync;
    end
  end

  assign pin_drive = pin_r;

endmodule

// ### tpc_consts.svh
// Register map, field positions and reset values of the timer/PWM block.
// Assumes a 32-bit bus with one 8-bit register per aligned word.
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// ==========================================================================
// Word indices (byte address = index * 4)
`define TPC_IDX_TSC     4'h0
`define TPC_IDX_CNTH    4'h1
`define TPC_IDX_CNTL    4'h2
`define TPC_IDX_MODH    4'h3
`define TPC_IDX_MODL    4'h4
`define TPC_IDX_CH0SC   4'h5
`define TPC_IDX_CH0H    4'h6
`define TPC_IDX_CH0L    4'h7
`define TPC_IDX_CH1SC   4'h8
`define TPC_IDX_CH1H    4'h9
`define TPC_IDX_CH1L    4'ha

// ==========================================================================
// Timer control/status fields
`define TPC_TSC_TOF     7
`define TPC_TSC_OVERFLOW_IRQ_ENABLE    6
`define TPC_TSC_STOP    5
`define TPC_TSC_CRST    4
`define TPC_CH_FLAG     7

// ==========================================================================
// Reset values and codes
`define TPC_STOP_RESET  1'b1
`define TPC_MOD_RESET   16'hffff
`define TPC_VAL_RESET   16'h0000
`define TPC_PS_EXT      3'h7
`define TPC_DIV_W       6

`endif

// ### tpc_cpu_model.sv
// CPU stand-in: classic Wishbone master for the timer registers.
// Assumes the slave acks every request; the bench bounds any hang.
`timescale 1ns/1ns
module tpc_cpu_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [3:0]  sel,
  output logic      [5:0]  adr,
  output logic      [31:0] wdat
);
  // ==========================================================================
  // Bus cycles
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 6'h00;
    wdat = 32'h0;
  end

  // One request, held until ack; data inverted on release so nothing stale lingers
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~{24'h0, d};
  endtask
endmodule

// ### tpc_pkg.sv
// Types shared by the timer/PWM block.
// Assumes nothing of its surroundings.
package tpc_pkg;

  // ==========================================================================
  // Edge/level select encodings
  typedef enum logic [1:0] {
    TPC_ELS_OFF = 2'h0,
    TPC_ELS_TGL = 2'h1,
    TPC_ELS_CLR = 2'h2,
    TPC_ELS_SET = 2'h3
  } tpc_els_t;

  // ==========================================================================
  // Channel control/status word, bit 7 down to bit 0
  typedef struct packed {
    logic     flag;
    logic     ie;
    logic     msb;
    logic     msa;
    tpc_els_t els;
    logic     tov;
    logic     maxd;
  } tpc_chsc_t;

endpackage

// ### tpc_prescaler.sv
// Timer clock source: bus clock divided by 1..64 or the external pin.
// Assumes the external pin is asynchronous; it is synchronised here.
`timescale 1ns/1ns
`include "tpc_consts.svh"
module tpc_prescaler
  import tpc_pkg::*;
#(
  parameter int DIV_W = `TPC_DIV_W
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] ps,
  input  wire logic       clr,
  input  wire logic       ext_pin,
  output logic            tick
);

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask;
  logic [2:0]       ext_r;
  logic [2:0]       ext_nxt;

  // ==========================================================================
  // Divider and pin synchroniser; ext_r[0] feeds only ext_r[1]
  always_comb begin
    div_nxt = clr ? '0 : div_r + 1'b1;
    ext_nxt = {ext_r[1:0], ext_pin};
    mask    = ~({DIV_W{1'b1}} << ps);
    if (ps == `TPC_PS_EXT) begin
      tick = ext_r[1] & ~ext_r[2];            // Rising pin edge
    end else begin
      tick = (div_r & mask) == mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      ext_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
      ext_r <= ext_nxt;
    end
  end

endmodule

// ### tpc_timer.sv
// Two-channel 16-bit timer with prescaler, modulo counter and buffered PWM.
// Assumes a classic Wishbone master on clk and asynchronous channel pins.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "tpc_consts.svh"
module tpc_timer
  import tpc_pkg::*;
#(
  parameter int DIV_W = `TPC_DIV_W
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        wait_mode,
  input  wire logic        break_active,
  input  wire logic        break_clear_enable,
  input  wire logic        external_timer_clock_pin,
  input  wire logic        chan0_pin_level,
  input  wire logic        chan1_pin_level,
  output logic             chan0_pin_drive,
  output logic             chan0_pin_oe,
  output logic             chan1_pin_drive,
  output logic             chan1_pin_oe,
  output logic             ext_clk_input_force,
  output logic             timer_irq
);

  localparam logic [3:0] SC_IDX [2] = '{`TPC_IDX_CH0SC, `TPC_IDX_CH1SC};
  localparam logic [3:0] H_IDX  [2] = '{`TPC_IDX_CH0H, `TPC_IDX_CH1H};
  localparam logic [3:0] L_IDX  [2] = '{`TPC_IDX_CH0L, `TPC_IDX_CH1L};

  // ==========================================================================
  // Helpers
  // Two-step flag clear; a set in the same cycle wins and drops the arm
  function automatic logic [1:0] flag_upd(input logic flag, input logic arm, input logic set,
                                          input logic rd_hit, input logic wr_hit, input logic wbit,
                                          input logic allow);
    logic f;
    logic a;
    f = flag;
    a = arm;
    if (rd_hit && flag && allow) a = 1'b1;
    if (wr_hit && allow) begin
      if (!wbit && arm) f = 1'b0;
      a = 1'b0;
    end
    if (set) begin
      f = 1'b1;
      a = 1'b0;
    end
    return {f, a};
  endfunction

  function automatic logic cap_mode(input tpc_chsc_t c);
    return !c.msb && !c.msa && c.els != TPC_ELS_OFF;
  endfunction

  // ==========================================================================
  // State
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_nxt;
  logic        overflow_irq_enable_r, overflow_irq_enable_nxt, stop_r, stop_nxt;
  logic [2:0]  ps_r, ps_nxt;
  logic        tof_r, tof_nxt, tof_arm_r, tof_arm_nxt;
  logic [15:0] cnt_r, cnt_nxt, mod_r, mod_nxt;
  logic [7:0]  cnt_buf_r, cnt_buf_nxt, modh_buf_r, modh_buf_nxt;
  logic        cnt_lat_r, cnt_lat_nxt, mod_inh_r, mod_inh_nxt;
  tpc_chsc_t   chsc_r [2];
  tpc_chsc_t   chsc_nxt [2];
  logic        chf_arm_r [2];
  logic        chf_arm_nxt [2];
  logic [15:0] val_r [2];
  logic [15:0] val_nxt [2];
  logic [7:0]  valh_r [2];
  logic [7:0]  valh_nxt [2];
  logic        vinh_r [2];
  logic        vinh_nxt [2];
  logic        act_sel_r, act_sel_nxt, last_wr_r, last_wr_nxt;
  logic        irq_nxt, force_nxt;
  logic [1:0]  pin_s1_r, pin_s2_r;

  // ==========================================================================
  // Bus decode; while waiting the bus still gets an answer but no effect
  logic       acc, rd, wr, allow, linked, tick, run_tick, cnt_clr, at_mod, ovf_evt, tof_set;
  logic [3:0] idx;
  logic [7:0] wdat;
  logic [1:0] cmp_hit, cap_evt, cmp_evt;
  logic [15:0] cmp_val0;

  assign acc      = wb_cyc_i & wb_stb_i & ~ack_r & ~wait_mode;
  assign rd       = acc & ~wb_we_i;
  assign wr       = acc & wb_we_i & wb_sel_i[0];
  assign idx      = wb_adr_i[5:2];
  assign wdat     = wb_dat_i[7:0];
  assign allow    = ~break_active | break_clear_enable;
  assign linked   = chsc_r[0].msb;

  // ==========================================================================
  // Counter events
  assign cnt_clr  = wr && idx == `TPC_IDX_TSC && wdat[`TPC_TSC_CRST];
  assign run_tick = tick & ~stop_r & ~break_active;
  assign at_mod   = cnt_r == mod_r;
  assign ovf_evt  = run_tick & at_mod & ~cnt_clr;
  assign tof_set  = ovf_evt & ~mod_inh_r;
  // Linked channel 0 compares against whichever pair is active
  assign cmp_val0 = (linked && act_sel_r) ? val_r[1] : val_r[0];
  assign cmp_hit[0] = run_tick & ~cnt_clr & (cnt_r == cmp_val0)
                    & ~vinh_r[(linked && act_sel_r) ? 1 : 0];
  assign cmp_hit[1] = run_tick & ~cnt_clr & (cnt_r == val_r[1]) & ~vinh_r[1];

  tpc_prescaler #(
    .DIV_W (DIV_W)
  ) u_presc (
    .clk     (clk),
    .rst_n   (rst_n),
    .ps      (ps_r),
    .clr     (cnt_clr),
    .ext_pin (external_timer_clock_pin),
    .tick    (tick)
  );

  tpc_channel u_ch0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .ctrl      (chsc_r[0]),
    .enable    (1'b1),
    .cmp_hit   (cmp_hit[0]),
    .ovf       (ovf_evt),
    .pin_sync  (pin_s2_r[0]),
    .pin_drive (chan0_pin_drive),
    .pin_oe    (chan0_pin_oe),
    .cap_evt   (cap_evt[0]),
    .cmp_evt   (cmp_evt[0])
  );

  // Channel 1 sits idle and releases its pin while linked
  tpc_channel u_ch1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .ctrl      (chsc_r[1]),
    .enable    (~linked),
    .cmp_hit   (cmp_hit[1]),
    .ovf       (ovf_evt),
    .pin_sync  (pin_s2_r[1]),
    .pin_drive (chan1_pin_drive),
    .pin_oe    (chan1_pin_oe),
    .cap_evt   (cap_evt[1]),
    .cmp_evt   (cmp_evt[1])
  );

  // ==========================================================================
  // Next-state for registers, counter and flags
  always_comb begin
    ack_nxt      = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt     = 32'h0;
    overflow_irq_enable_nxt     = overflow_irq_enable_r;
    stop_nxt     = stop_r;
    ps_nxt       = ps_r;
    cnt_buf_nxt  = cnt_buf_r;
    cnt_lat_nxt  = cnt_lat_r;
    mod_nxt      = mod_r;
    modh_buf_nxt = modh_buf_r;
    mod_inh_nxt  = mod_inh_r;
    chsc_nxt     = chsc_r;
    chf_arm_nxt  = chf_arm_r;
    val_nxt      = val_r;
    valh_nxt     = valh_r;
    vinh_nxt     = vinh_r;
    act_sel_nxt  = act_sel_r;
    last_wr_nxt  = last_wr_r;
    // Overflow flag and control bits
    {tof_nxt, tof_arm_nxt} = flag_upd(tof_r, tof_arm_r, tof_set, rd && idx == `TPC_IDX_TSC,
                                      wr && idx == `TPC_IDX_TSC, wdat[`TPC_TSC_TOF], allow);
    if (wr && idx == `TPC_IDX_TSC) begin
      overflow_irq_enable_nxt = wdat[`TPC_TSC_OVERFLOW_IRQ_ENABLE];
      stop_nxt = wdat[`TPC_TSC_STOP];
      ps_nxt   = wdat[2:0];
    end
    // Counter: reset wins, then wrap at modulo
    if (cnt_clr) begin
      cnt_nxt = 16'h0;
    end else if (run_tick) begin
      cnt_nxt = at_mod ? 16'h0 : cnt_r + 16'h1;
    end else begin
      cnt_nxt = cnt_r;
    end
    // Modulo pair loads as a unit on the low-byte write
    if (wr && idx == `TPC_IDX_MODH) begin
      modh_buf_nxt = wdat;
      mod_inh_nxt  = 1'b1;
    end
    if (wr && idx == `TPC_IDX_MODL) begin
      mod_nxt     = {modh_buf_r, wdat};
      mod_inh_nxt = 1'b0;
    end
    // Reads of the shared registers; the reset bit always reads 0
    if (rd) begin
      case (idx)
        `TPC_IDX_TSC:  rdat_nxt = {24'h0, tof_r, overflow_irq_enable_r, stop_r, 2'h0, ps_r};
        `TPC_IDX_CNTH: begin
          rdat_nxt = {24'h0, cnt_r[15:8]};
          if (!cnt_lat_r) begin
            cnt_buf_nxt = cnt_r[7:0];
            cnt_lat_nxt = 1'b1;
          end
        end
        `TPC_IDX_CNTL: begin
          rdat_nxt    = {24'h0, cnt_lat_r ? cnt_buf_r : cnt_r[7:0]};
          cnt_lat_nxt = 1'b0;
        end
        `TPC_IDX_MODH: rdat_nxt = {24'h0, mod_r[15:8]};
        `TPC_IDX_MODL: rdat_nxt = {24'h0, mod_r[7:0]};
        default:       rdat_nxt = 32'h0;
      endcase
    end
    // Per-channel control, value pairs and flags
    for (int i = 0; i < 2; i++) begin
      {chsc_nxt[i].flag, chf_arm_nxt[i]} = flag_upd(chsc_r[i].flag, chf_arm_r[i], cap_evt[i] | cmp_evt[i],
                                                    rd && idx == SC_IDX[i], wr && idx == SC_IDX[i],
                                                    wdat[`TPC_CH_FLAG], allow);
      if (wr && idx == SC_IDX[i]) begin
        chsc_nxt[i].ie   = wdat[6];
        chsc_nxt[i].msb  = (i == 0) ? wdat[5] : 1'b0;
        chsc_nxt[i].msa  = wdat[4];
        chsc_nxt[i].els  = tpc_els_t'(wdat[3:2]);
        chsc_nxt[i].tov  = wdat[1];
        chsc_nxt[i].maxd = wdat[0];
      end
      if (rd && idx == SC_IDX[i]) rdat_nxt = {24'h0, chsc_r[i]};
      if (rd && idx == H_IDX[i]) begin
        rdat_nxt = {24'h0, val_r[i][15:8]};
        if (cap_mode(chsc_r[i])) vinh_nxt[i] = 1'b1;
      end
      if (rd && idx == L_IDX[i]) begin
        rdat_nxt = {24'h0, val_r[i][7:0]};
        if (cap_mode(chsc_r[i])) vinh_nxt[i] = 1'b0;
      end
      if (wr && idx == H_IDX[i]) begin
        valh_nxt[i] = wdat;
        if (!cap_mode(chsc_r[i])) vinh_nxt[i] = 1'b1;
      end
      if (wr && idx == L_IDX[i]) begin
        val_nxt[i]  = {valh_r[i], wdat};
        vinh_nxt[i] = 1'b0;
        last_wr_nxt = (i == 1);
      end
      if (cap_evt[i] && !vinh_r[i]) val_nxt[i] = cnt_r;
    end
    // Active pair swaps only at an overflow; unlinked resets to channel 0
    if (!linked) begin
      act_sel_nxt = 1'b0;
      last_wr_nxt = 1'b0;
    end else if (ovf_evt) begin
      act_sel_nxt = last_wr_r;
    end
    // One request line; it is also the wake source in wait mode
    irq_nxt   = (tof_r & overflow_irq_enable_r) | (chsc_r[0].flag & chsc_r[0].ie)
              | (chsc_r[1].flag & chsc_r[1].ie & ~linked);
    force_nxt = ps_r == `TPC_PS_EXT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r      <= 1'b0;
      wb_dat_o   <= 32'h0;
      overflow_irq_enable_r     <= 1'b0;
      stop_r     <= `TPC_STOP_RESET;
      ps_r       <= 3'h0;
      tof_r      <= 1'b0;
      tof_arm_r  <= 1'b0;
      cnt_r      <= 16'h0;
      cnt_buf_r  <= 8'h0;
      cnt_lat_r  <= 1'b0;
      mod_r      <= `TPC_MOD_RESET;
      modh_buf_r <= 8'h0;
      mod_inh_r  <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        chsc_r[i]    <= '0;
        chf_arm_r[i] <= 1'b0;
        val_r[i]     <= `TPC_VAL_RESET;
        valh_r[i]    <= 8'h0;
        vinh_r[i]    <= 1'b0;
      end
      act_sel_r  <= 1'b0;
      last_wr_r  <= 1'b0;
      timer_irq  <= 1'b0;
      ext_clk_input_force <= 1'b0;
      pin_s1_r   <= 2'h0;
      pin_s2_r   <= 2'h0;
    end else begin
      ack_r      <= ack_nxt;
      wb_dat_o   <= rdat_nxt;
      overflow_irq_enable_r     <= overflow_irq_enable_nxt;
      stop_r     <= stop_nxt;
      ps_r       <= ps_nxt;
      tof_r      <= tof_nxt;
      tof_arm_r  <= tof_arm_nxt;
      cnt_r      <= cnt_nxt;
      cnt_buf_r  <= cnt_buf_nxt;
      cnt_lat_r  <= cnt_lat_nxt;
      mod_r      <= mod_nxt;
      modh_buf_r <= modh_buf_nxt;
      mod_inh_r  <= mod_inh_nxt;
      chsc_r     <= chsc_nxt;
      chf_arm_r  <= chf_arm_nxt;
      val_r      <= val_nxt;
      valh_r     <= valh_nxt;
      vinh_r     <= vinh_nxt;
      act_sel_r  <= act_sel_nxt;
      last_wr_r  <= last_wr_nxt;
      timer_irq  <= irq_nxt;
      ext_clk_input_force <= force_nxt;
      pin_s1_r   <= {chan1_pin_level, chan0_pin_level};
      pin_s2_r   <= pin_s1_r;
    end
  end

  assign wb_ack_o = ack_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HALT_HOLDS: assert property ((stop_r && !cnt_clr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  AST_BREAK_HOLDS: assert property ((break_active && !cnt_clr) |=> $stable(cnt_r))
    else $error("counter moved during break");
  AST_INCREMENT: assert property ((run_tick && !at_mod && !cnt_clr) |=> cnt_r == $past(cnt_r) + 16'h1)
    else $error("counter did not step by one");
  AST_WRAP_FLAG: assert property ((run_tick && at_mod && !cnt_clr && !mod_inh_r) |=> (cnt_r == 16'h0) && tof_r)
    else $error("no wrap or flag at modulo");
  AST_MODH_BLOCKS: assert property ((mod_inh_r && !tof_r && !(wr && idx == `TPC_IDX_MODL)) |=> !tof_r)
    else $error("flag set while modulo half written");
  AST_TOF_NEEDS_ARM: assert property ((tof_r && !tof_arm_r) |=> tof_r)
    else $error("flag cleared without prior read");
  AST_STOP_ZERO: assert property ((cnt_clr && wdat[`TPC_TSC_STOP] && !break_active) ##1 (!wr)[*3]
                                  |-> (cnt_r == 16'h0))
    else $error("stopped counter left zero");
  AST_TSC_RST_READS0: assert property ((wb_ack_o && !wb_we_i && idx == `TPC_IDX_TSC) |-> !wb_dat_o[`TPC_TSC_CRST])
    else $error("counter reset bit read as one");
  AST_IRQ_GATE: assert property ((!overflow_irq_enable_r && !(chsc_r[0].flag && chsc_r[0].ie) && !chsc_r[1].ie) |=> !timer_irq)
    else $error("request without enable");
  AST_BUF_SWAP: assert property ((linked && ovf_evt) |=> act_sel_r == $past(last_wr_r))
    else $error("active pair not last written");
  AST_CH1_RELEASED: assert property ((linked && $past(linked)) |-> !chan1_pin_oe)
    else $error("channel 1 pin driven while linked");
  AST_EXT_INPUT: assert property ((ps_r == `TPC_PS_EXT) |=> ext_clk_input_force)
    else $error("clock pin not forced to input");
  AST_WAIT_LOCK: assert property ((wait_mode && wb_cyc_i && wb_stb_i) |=> $stable(stop_r) && $stable(mod_r))
    else $error("register changed in wait");

  COV_OVERFLOW: cover property (ovf_evt && overflow_irq_enable_r ##1 timer_irq);
  COV_SWAP_CH1: cover property (linked && ovf_evt && last_wr_r ##1 act_sel_r);
  COV_CAPTURE:  cover property (cap_evt[0] && !vinh_r[0]);
  COV_TOF_CLEAR: cover property (tof_r && tof_arm_r ##1 !tof_r);

endmodule

// ### tpc_timer_bench.sv
// Self-checking bench of the timer: registers, overflow flag, halt and reset.
// Assumes the CPU model drives the bus; capture pins held low, break and clock pin driven here.
`timescale 1ns/1ns
module tpc_timer_bench;
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wait_mode, timer_irq;
  logic [3:0]  wb_sel_i;
  logic [5:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0]  q, m, w;
  logic        brk, ext_pin, pin0, oe0, pin1, oe1, xforce;
  int          failures, n_tests;

  // ==========================================================================
  // Design and partner
  tpc_timer DUT (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wait_mode, .break_active(brk), .break_clear_enable(1'b0), .external_timer_clock_pin(ext_pin),
    .chan0_pin_level(1'b0), .chan1_pin_level(1'b0), .chan0_pin_drive(pin0), .chan0_pin_oe(oe0),
    .chan1_pin_drive(pin1), .chan1_pin_oe(oe1), .ext_clk_input_force(xforce), .timer_irq);
  tpc_cpu_model cpu (.clk, .ack(wb_ack_o), .rdat(wb_dat_o), .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
    .sel(wb_sel_i), .adr(wb_adr_i), .wdat(wb_dat_i));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] ctl(int f, int ie, int h, logic [2:0] ps);
    return {1'(f), 1'(ie), 1'(h), 2'b00, ps};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    cpu.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask

  // High cycles of the channel 0 pin over n edges; whole periods make the phase irrelevant
  task automatic duty(input int n, input int exp);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge clk);
      if (pin0 !== 1'b0) h++;                 // Unknown counts as high so it cannot pass, except where full duty is expected
    end
    chk(8'(h), 8'(exp));
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog; the tests need well under a thousand cycles
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    wait_mode = 1'b0;
    failures = 0;
    n_tests = 0;
    q = 8'h00;
    w = 8'h00;
    brk = 1'b0;
    ext_pin = 1'b0;
    void'($urandom(32'h488fbf92));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(6'h00, ctl(0, 0, 1, 3'h0));
    rd_chk(6'h0c, 8'hff);
    rd_chk(6'h04, 8'h00);
    rd_chk(6'h3c, 8'h00);
    chk({4'h0, pin1, oe1, pin0, oe0}, 8'h0a);
    $display("test reset done");
    // Random short period keeps overflow within a few dozen cycles
    m = 8'h03 + 8'($urandom_range(7));
    wr(6'h0c, 8'h00);
    wr(6'h10, m);
    wr(6'h00, 8'h10);
    for (int i = 0; i < 20 && q[7] !== 1'b1; i++) cpu.xfer(1'b0, 6'h00, 8'h00, q);
    chk(q, ctl(1, 0, 0, 3'h0));
    chk({7'h0, timer_irq}, 8'h00);
    wr(6'h00, 8'he0);
    rd_chk(6'h00, ctl(1, 1, 1, 3'h0));
    chk({7'h0, timer_irq}, 8'h01);
    wr(6'h00, 8'h60);
    rd_chk(6'h00, ctl(0, 1, 1, 3'h0));
    chk({7'h0, timer_irq}, 8'h00);
    $display("test overflow done");
    wr(6'h00, 8'h30);
    rd_chk(6'h04, 8'h00);
    rd_chk(6'h08, 8'h00);
    wait_mode <= 1'b1;
    rd_chk(6'h10, 8'h00);
    wait_mode <= 1'b0;
    rd_chk(6'h10, m);
    $display("test halt and wait done");
    // Unbuffered PWM, clear on compare: high from overflow through compare
    w = m >> 1;
    wr(6'h00, 8'h30);
    wr(6'h18, 8'h00);
    wr(6'h1c, w);
    wr(6'h14, 8'h1a);
    wr(6'h00, 8'h00);
    duty(4 * (m + 1), 4 * (w + 1));
    wr(6'h14, 8'h1b);
    repeat (2 * (m + 1)) @(posedge clk);
    duty(2 * (m + 1), 2 * (m + 1));
    wr(6'h14, 8'h18);
    repeat (2 * (m + 1)) @(posedge clk);
    duty(2 * (m + 1), 0);
    $display("test pwm done");
    // Linked pair: channel 0 value first, channel 1 pair after its write
    wr(6'h00, 8'h30);
    wr(6'h14, 8'h3a);
    wr(6'h00, 8'h00);
    repeat (m + 1) @(posedge clk);
    duty(2 * (m + 1), 2 * (w + 1));
    chk({6'h0, oe1, oe0}, 8'h01);
    wr(6'h24, 8'h00);
    wr(6'h28, m - 8'h01);
    repeat (m + 1) @(posedge clk);
    duty(2 * (m + 1), 2 * m);
    $display("test buffered pwm done");
    // External clock pin: two rising edges give a count of two
    wr(6'h00, 8'h37);
    wr(6'h00, 8'h07);
    chk({7'h0, xforce}, 8'h01);
    repeat (4) begin
      repeat (4) @(posedge clk);
      ext_pin <= ~ext_pin;
    end
    repeat (4) @(posedge clk);
    rd_chk(6'h08, 8'h02);
    // Break freezes a running counter between two reads
    wr(6'h00, 8'h10);
    brk <= 1'b1;
    cpu.xfer(1'b0, 6'h08, 8'h00, q);
    rd_chk(6'h08, q);
    brk <= 1'b0;
    $display("test clock pin and break done");
    stop_test();
  end
endmodule
